// ---- core/sttr_pkg.sv ----
// Purpose : shared constants and types for the subtract / table-read datapath
// Assumes : 16-bit data words, 32-bit accumulator, 16-bit program addresses
// Notes   : opcodes carry the 9 upper instruction bits; bit 7 picks mode
package sttr_pkg;
    // *****************************************************************
    // widths and opcode fields
    // *****************************************************************
    localparam int          WORD_W       = 16;
    localparam int          ACC_W        = 32;
    localparam logic [8:0]  OPC_SUB_UNS  = 9'h0cc;  // bits 15..7 direct
    localparam logic [8:0]  OPC_SUB_SHF  = 9'h0ce;
    localparam logic [8:0]  OPC_TBL_RD   = 9'h14c;
    localparam int          OPC_HI       = 15;
    localparam int          OPC_LO       = 7;
    localparam int          MODE_BIT     = 7;
    localparam int          DMA_HI       = 6;
    localparam int          SHIFT_HI     = 3;
    localparam int          ARN_HI       = 2;
    localparam logic [15:0] RESET_WORD   = 16'h0000;
    localparam logic [31:0] RESET_ACC    = 32'h0000_0000;
    localparam logic [31:0] ACC_POS_MAX  = 32'h7fff_ffff;
    localparam logic [31:0] ACC_NEG_MAX  = 32'h8000_0000;
    localparam logic [15:0] ONE_WORD     = 16'h0001;

    // *****************************************************************
    // execution state
    // *****************************************************************
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_WAIT  = 3'b001,
        ST_TRD1  = 3'b010,
        ST_TRD2  = 3'b011,
        ST_TRDW  = 3'b100
    } sttr_state_type;

    // memory placement of operand / code, decides cycle counts
    typedef struct packed {
        logic operand_ext;    // data operand in external memory
        logic code_ext;       // code in external memory
        logic shared_single;  // operand and code in one single_access_block
        logic src_dst_shared; // source and destination share a block
    } sttr_place_type;

    typedef struct packed {
        logic sign_extension_mode;
        logic overflow_saturate_mode;
        logic temp_register_mode;
    } sttr_mode_type;
endpackage : sttr_pkg

// ---- core/sttr_core.sv ----
// Purpose : execution datapath for unsigned subtract, shifted subtract and
//           table read, with repeat support
// Assumes : memories answer reads combinationally; wait states are given
//           as counts d (data) and p (program) on ports
// Notes   : one instruction accepted at a time while ready_o is high
//
// Contract
// - unsigned subtract equals general subtract, no sign extension, shift 0
// - unsigned subtract operand is 16-bit unsigned, accumulator signed
// - shifted subtract shifts operand by low 4 bits of shift temp
// - shifted subtract sign-extends operand only in sign extension mode
// - carry cleared on borrow else set; overflow updated, saturate per mode
// - temp mode clear: load of first temp writes all three temps
// - subtract takes 1, 2 shared, 1+d external, 2+d+p all external
// - repeated subtract takes n, n+1 shared, external adds waits
// - table read saves prefetch counter to call stack, loads acc low
// - table read moves program word at prefetch counter into data memory
// - each repeat iteration moves, bumps counter; last restores prefetch
// - repeated table read with no shared block moves one word per cycle once primed
// - single table read takes 3, or 4 with shared destination block
// - repeated table read takes n+2, or 2n when source/destination share
// - repeated table read takes 2n+2 when all share one block
`timescale 1ns/100ps
`default_nettype none
module sttr_core (
    input  wire logic                   core_clk_i,   // core clock
    input  wire logic                   reset_i,      // sync reset
    input  wire logic                   issue_i,      // instruction valid
    input  wire logic [15:0]            instr_i,      // instruction word
    input  wire logic [15:0]            repeat_i,     // repeat count (n-1)
    input  wire sttr_pkg::sttr_place_type place_i,    // memory placement
    input  wire logic [3:0]             wait_d_i,     // data wait states
    input  wire logic [3:0]             wait_p_i,     // program wait states
    input  wire sttr_pkg::sttr_mode_type  mode_i,     // status mode bits
    input  wire logic                   tload_i,      // load first temp
    input  wire logic [15:0]            tload_data_i, // temp load value
    input  wire logic [15:0]            dmem_rdata_i, // data memory read
    input  wire logic [15:0]            pmem_rdata_i, // program memory read
    output logic                        ready_o,      // can accept
    output logic [15:0]                 dmem_addr_o,  // data address
    output logic                        dmem_we_o,    // data write
    output logic [15:0]                 dmem_wdata_o, // data write value
    output logic [15:0]                 pmem_addr_o,  // program address
    output logic [31:0]                 acc_o,        // accumulator
    output logic                        carry_o,      // carry flag
    output logic                        overflow_o,   // overflow_flag
    output logic [15:0]                 shift_temp_o  // shift temp value
);
    // *****************************************************************
    // state
    // *****************************************************************
    sttr_pkg::sttr_state_type state;
    logic [31:0] acc;
    logic        carry;
    logic        overflow_flag;
    logic [15:0] first_temp_register;
    logic [15:0] shift_temp_register;
    logic [15:0] product_temp_register;
    logic [15:0] prefetch_counter;
    logic [15:0] micro_call_stack;
    logic [15:0] rpt_cnt;
    logic [7:0]  wait_cnt;
    logic [15:0] aux_reg [0:7];
    logic [2:0]  aux_register_pointer;
    logic [15:0] dest_addr;
    logic        shared_dst;
    logic [15:0] pword;

    logic [8:0]  opc;
    logic        is_uns;
    logic        is_shf;
    logic        is_tbl;
    logic [15:0] next_addr;
    logic [33:0] ext_op;
    logic [33:0] diff;
    logic [31:0] next_acc;
    logic        next_ovf;
    logic [7:0]  sub_cycles;

    assign opc    = instr_i[sttr_pkg::OPC_HI:sttr_pkg::OPC_LO] &
                    9'h1fe;
    assign is_uns = opc == sttr_pkg::OPC_SUB_UNS;
    assign is_shf = opc == sttr_pkg::OPC_SUB_SHF;
    assign is_tbl = opc == sttr_pkg::OPC_TBL_RD;

    always_comb begin
        if (!instr_i[sttr_pkg::MODE_BIT]) begin
            next_addr = {9'h000, instr_i[sttr_pkg::DMA_HI:0]};
        end else begin
            next_addr = aux_reg[aux_register_pointer];
        end
    end

    // *****************************************************************
    // subtract arithmetic
    // *****************************************************************
    // unsigned operand, no shift; shifted subtract extends and shifts it
    always_comb begin
        ext_op = {18'h00000, dmem_rdata_i};
        if (is_shf) begin
            if (mode_i.sign_extension_mode) begin
                ext_op = {{18{dmem_rdata_i[15]}}, dmem_rdata_i};
            end
            ext_op = ext_op << shift_temp_register[sttr_pkg::SHIFT_HI:0];
        end
        diff = {{2{acc[31]}}, acc} - ext_op;
        next_ovf = diff[32] != diff[31];
        next_acc = diff[31:0];
        if (next_ovf && mode_i.overflow_saturate_mode) begin
            next_acc = diff[33] ? sttr_pkg::ACC_NEG_MAX
                                : sttr_pkg::ACC_POS_MAX;
        end
    end

    // extra cycles beyond one per iteration
    always_comb begin
        sub_cycles = 8'h00;
        if (place_i.operand_ext) begin
            sub_cycles = sub_cycles + {4'h0, wait_d_i};
        end
        if (place_i.operand_ext && place_i.code_ext) begin
            sub_cycles = sub_cycles + 8'h01 + {4'h0, wait_p_i};
        end else if (place_i.code_ext) begin
            sub_cycles = sub_cycles + {4'h0, wait_p_i};
        end else if (place_i.shared_single) begin
            sub_cycles = 8'h01;
        end
    end

    // *****************************************************************
    // sequencer
    // *****************************************************************
    // simplification: wait terms are paid once up front, then one
    // iteration per cycle; the accumulator updates per iteration
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            state            <= sttr_pkg::ST_IDLE;
            acc              <= sttr_pkg::RESET_ACC;
            carry            <= 1'b0;
            overflow_flag    <= 1'b0;
            prefetch_counter <= sttr_pkg::RESET_WORD;
            micro_call_stack <= sttr_pkg::RESET_WORD;
            rpt_cnt          <= sttr_pkg::RESET_WORD;
            wait_cnt         <= 8'h00;
            dest_addr        <= sttr_pkg::RESET_WORD;
            shared_dst       <= 1'b0;
            pword            <= sttr_pkg::RESET_WORD;
        end else begin
            case (state)
                sttr_pkg::ST_IDLE: begin
                    if (issue_i && is_tbl) begin
                        micro_call_stack <= prefetch_counter;
                        prefetch_counter <= acc[15:0];
                        rpt_cnt          <= repeat_i;
                        dest_addr        <= next_addr;
                        shared_dst       <= place_i.shared_single |
                                            place_i.src_dst_shared;
                        pword            <= pmem_rdata_i;
                        state            <= (place_i.src_dst_shared &&
                            !place_i.shared_single &&
                            repeat_i != sttr_pkg::RESET_WORD) ?
                            sttr_pkg::ST_TRDW : sttr_pkg::ST_TRD1;
                    end else if (issue_i && (is_uns || is_shf)) begin
                        rpt_cnt  <= repeat_i;
                        dest_addr <= next_addr;
                        wait_cnt <= sub_cycles;
                        state    <= sttr_pkg::ST_WAIT;
                    end
                end
                sttr_pkg::ST_WAIT: begin
                    if (wait_cnt != 8'h00) begin
                        wait_cnt <= wait_cnt - 8'h01;
                    end else begin
                        acc           <= next_acc;
                        carry         <= (acc >= ext_op[31:0]);
                        overflow_flag <= next_ovf;
                        if (rpt_cnt == sttr_pkg::RESET_WORD) begin
                            state <= sttr_pkg::ST_IDLE;
                        end else begin
                            rpt_cnt <= rpt_cnt - sttr_pkg::ONE_WORD;
                        end
                    end
                end
                sttr_pkg::ST_TRD1: begin
                    state <= sttr_pkg::ST_TRD2;
                end
                sttr_pkg::ST_TRD2: begin
                    pword <= pmem_rdata_i;
                    state <= shared_dst ? sttr_pkg::ST_TRDW
                                        : sttr_pkg::ST_TRD2;
                    if (!shared_dst) begin
                        if (rpt_cnt == sttr_pkg::RESET_WORD) begin
                            prefetch_counter <= micro_call_stack;
                            state            <= sttr_pkg::ST_IDLE;
                        end else begin
                            prefetch_counter <= prefetch_counter +
                                                sttr_pkg::ONE_WORD;
                            rpt_cnt <= rpt_cnt - sttr_pkg::ONE_WORD;
                        end
                    end
                end
                sttr_pkg::ST_TRDW: begin
                    // shared block: two cycles per word
                    if (rpt_cnt == sttr_pkg::RESET_WORD) begin
                        prefetch_counter <= micro_call_stack;
                        state            <= sttr_pkg::ST_IDLE;
                    end else begin
                        prefetch_counter <= prefetch_counter +
                                            sttr_pkg::ONE_WORD;
                        rpt_cnt <= rpt_cnt - sttr_pkg::ONE_WORD;
                        state   <= sttr_pkg::ST_TRD2;
                    end
                end
                default: begin
                    state <= sttr_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // data memory write of the moved word
    logic wr_now;
    logic [15:0] wr_addr;
    assign wr_now = (state == sttr_pkg::ST_TRD2 && !shared_dst) ||
                    state == sttr_pkg::ST_TRDW;

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            dmem_we_o    <= 1'b0;
            dmem_wdata_o <= sttr_pkg::RESET_WORD;
            wr_addr      <= sttr_pkg::RESET_WORD;
        end else begin
            dmem_we_o    <= wr_now;
            wr_addr <= instr_i[sttr_pkg::MODE_BIT] ? next_addr : dest_addr;
            dmem_wdata_o <= (state == sttr_pkg::ST_TRDW) ? pword
                                                         : pmem_rdata_i;
        end
    end

    // aux registers: post-increment in indirect table read
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_aux
            always_ff @(posedge core_clk_i) begin
                if (reset_i) begin
                    aux_reg[gi] <= sttr_pkg::RESET_WORD;
                end else if (wr_now && instr_i[sttr_pkg::MODE_BIT] &&
                             aux_register_pointer == gi[2:0]) begin
                    aux_reg[gi] <= aux_reg[gi] + sttr_pkg::ONE_WORD;
                end
            end
        end
    endgenerate

    // pointer change not modelled; pointer fixed after reset
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            aux_register_pointer <= 3'h0;
        end else begin
            aux_register_pointer <= aux_register_pointer;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            first_temp_register   <= sttr_pkg::RESET_WORD;
            shift_temp_register   <= sttr_pkg::RESET_WORD;
            product_temp_register <= sttr_pkg::RESET_WORD;
        end else if (tload_i) begin
            first_temp_register <= tload_data_i;
            if (!mode_i.temp_register_mode) begin
                shift_temp_register   <= tload_data_i;
                product_temp_register <= tload_data_i;
            end
        end
    end

    // outputs
    assign ready_o      = state == sttr_pkg::ST_IDLE;
    // a write lags its state by one cycle, so its address is held with it
    assign dmem_addr_o  = dmem_we_o ? wr_addr :
                          (state == sttr_pkg::ST_IDLE) ? next_addr : dest_addr;
    assign pmem_addr_o  = (ready_o && issue_i && is_tbl) ? acc[15:0]
                                                         : prefetch_counter;
    assign acc_o        = acc;
    assign carry_o      = carry;
    assign overflow_o   = overflow_flag;
    assign shift_temp_o = shift_temp_register;

    // *****************************************************************
    // assertions
    // *****************************************************************
    a_tbl_save_pfc: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (ready_o && issue_i && is_tbl) |=> (micro_call_stack == $past(prefetch_counter)
        && prefetch_counter == $past(acc[15:0])))
        else $error("table read did not save prefetch");
    a_tbl_no_flags: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (state != sttr_pkg::ST_WAIT) |=> $stable(carry) && $stable(overflow_flag))
        else $error("flags changed outside subtract");
    a_temp_mirror: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (tload_i && !mode_i.temp_register_mode) |=> shift_temp_register == $past(tload_data_i))
        else $error("temp load not mirrored");
    a_sub_one_cyc: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (ready_o && issue_i && is_uns && repeat_i == 16'h0000 && place_i == 4'h0)
        |=> ##1 ready_o)
        else $error("onchip subtract not single cycle");
    a_tbl_three: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (ready_o && issue_i && is_tbl && repeat_i == 16'h0000 && place_i == 4'h0)
        |=> !ready_o ##1 !ready_o ##1 ready_o)
        else $error("single table read not three cycles");
    a_tbl_restore: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (state == sttr_pkg::ST_TRD2 && !shared_dst && rpt_cnt == 16'h0000)
        |=> prefetch_counter == $past(micro_call_stack))
        else $error("prefetch not restored");
    a_tbl_stream: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (state == sttr_pkg::ST_TRD2 && !shared_dst && rpt_cnt != 16'h0000)
        |=> prefetch_counter == $past(prefetch_counter) + 16'h0001 && dmem_we_o)
        else $error("repeat table read not one per cycle");
    a_carry_borrow: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (state == sttr_pkg::ST_WAIT && wait_cnt == 8'h00) |=> carry == $past(acc >= ext_op[31:0]))
        else $error("carry not borrow inverse");
    c_tbl_rpt: cover property (@(posedge core_clk_i) state == sttr_pkg::ST_TRDW);
    c_sub_shf: cover property (@(posedge core_clk_i) ready_o && issue_i && is_shf);
    c_ovf_sat: cover property (@(posedge core_clk_i) next_ovf && mode_i.overflow_saturate_mode);
endmodule : sttr_core
`default_nettype wire

// ---- verif/sttr_mem_model.sv ----
// Purpose : behavioural program and data memory beside the datapath
// Assumes : reads answer combinationally in the cycle that is addressed
// Notes   : only the low data page is backed; elsewhere a moving pattern
`timescale 1ns/100ps
`default_nettype none
module sttr_mem_model (
    input  wire logic        core_clk_i,   // core clock
    input  wire logic [15:0] dmem_addr_i,  // data address
    input  wire logic        dmem_we_i,    // data write
    input  wire logic [15:0] dmem_wdata_i, // data write value
    input  wire logic [15:0] pmem_addr_i,  // program address
    output logic      [15:0] dmem_rdata_o, // data read
    output logic      [15:0] pmem_rdata_o  // program read
);
    logic [15:0] mem [256];
    int          i;

    // start with distinct words so a wrong address never reads a match
    initial begin
        for (i = 0; i < 256; i++) begin
            mem[i] = ~i[15:0];
        end
    end

    // program space is a fixed pattern, every word unlike its neighbour
    assign pmem_rdata_o = pmem_addr_i ^ 16'h3c5a;
    // unbacked space shows the inverted address, never a stale value
    assign dmem_rdata_o = (dmem_addr_i[15:8] == 8'h00) ?
                          mem[dmem_addr_i[7:0]] : ~dmem_addr_i;

    // store moved words so a later read sees them
    always @(posedge core_clk_i) begin
        if (dmem_we_i && dmem_addr_i[15:8] == 8'h00) begin
            mem[dmem_addr_i[7:0]] <= dmem_wdata_i;
        end
    end
endmodule : sttr_mem_model
`default_nettype wire

// ---- verif/subtract_table_read_exec_tb.sv ----
// Purpose : self-checking bench for the subtract / table-read datapath
// Assumes : cycle counts are compared relative to the plain on-chip case
// Notes   : expected accumulator is tracked here from the inputs applied
`timescale 1ns/100ps
`default_nettype none
module subtract_table_read_exec_tb;
    logic                       core_clk_i, reset_i, issue_i, tload_i;
    logic [15:0]                instr_i, repeat_i, tload_data_i;
    sttr_pkg::sttr_place_type   place_i;
    sttr_pkg::sttr_mode_type    mode_i;
    logic [3:0]                 wait_d_i, wait_p_i;
    logic [15:0]                dmem_rdata_i, pmem_rdata_i, dmem_addr_o;
    logic [15:0]                dmem_wdata_o, pmem_addr_o, shift_temp_o;
    logic                       ready_o, dmem_we_o, carry_o, overflow_o;
    logic [31:0]                acc_o, acc_exp;
    logic                       c_exp, chk_addr;
    logic [15:0]                pfc0, dst0;
    int                         miscompares, checks_done, base, tbase, wr_cnt;

    sttr_core DUT (.core_clk_i(core_clk_i), .reset_i(reset_i),
        .issue_i(issue_i), .instr_i(instr_i), .repeat_i(repeat_i),
        .place_i(place_i), .wait_d_i(wait_d_i), .wait_p_i(wait_p_i),
        .mode_i(mode_i), .tload_i(tload_i), .tload_data_i(tload_data_i),
        .dmem_rdata_i(dmem_rdata_i), .pmem_rdata_i(pmem_rdata_i),
        .ready_o(ready_o), .dmem_addr_o(dmem_addr_o), .dmem_we_o(dmem_we_o),
        .dmem_wdata_o(dmem_wdata_o), .pmem_addr_o(pmem_addr_o),
        .acc_o(acc_o), .carry_o(carry_o), .overflow_o(overflow_o),
        .shift_temp_o(shift_temp_o));
    sttr_mem_model MEM (.core_clk_i(core_clk_i), .dmem_addr_i(dmem_addr_o),
        .dmem_we_i(dmem_we_o), .dmem_wdata_i(dmem_wdata_o),
        .pmem_addr_i(pmem_addr_o), .dmem_rdata_o(dmem_rdata_i),
        .pmem_rdata_o(pmem_rdata_i));

    initial begin
        core_clk_i = 1'b0;
        forever #10 core_clk_i = ~core_clk_i;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask : chk

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : give_verdict

    // each moved word is checked as it leaves, in order of arrival
    always @(posedge core_clk_i) begin
        if (dmem_we_o === 1'b1) begin
            chk("moved word", {16'h0, (pfc0 + wr_cnt[15:0]) ^ 16'h3c5a}, {16'h0, dmem_wdata_o});
            if (chk_addr) chk("dest address",
                {16'h0, dst0 + (instr_i[7] ? wr_cnt[15:0] : 16'h0)},
                {16'h0, dmem_addr_o});
            wr_cnt++;
        end
    end

    // issue one instruction, then count edges until ready returns
    task automatic run_op(input logic [15:0] ins, input logic [15:0] rep,
                          input logic [3:0] pl, input logic [3:0] wd,
                          input logic [3:0] wp, input logic [2:0] md, output int cyc);
        @(posedge core_clk_i);
        issue_i  <= 1'b1;
        instr_i  <= ins;
        repeat_i <= rep;
        place_i  <= sttr_pkg::sttr_place_type'(pl);
        wait_d_i <= wd;
        wait_p_i <= wp;
        mode_i   <= sttr_pkg::sttr_mode_type'(md);
        @(posedge core_clk_i);
        issue_i <= 1'b0;
        cyc = 0;
        #1;
        while (ready_o !== 1'b1) begin
            if (cyc > 300) begin
                miscompares++;
                give_verdict();
            end
            @(posedge core_clk_i);
            #1;
            cyc++;
        end
    endtask : run_op

    // subtract: op is the operand as the rules extend and shift it
    task automatic sub_step(input logic [15:0] ins, input logic [15:0] rep,
            input logic [31:0] op, input logic [3:0] pl, input logic [3:0] wd,
            input logic [3:0] wp, input logic [2:0] md, input int extra);
        int          cyc;
        logic [32:0] d;
        logic        v;
        run_op(ins, rep, pl, wd, wp, md, cyc);
        for (int k = 0; k <= rep; k++) begin
            d = {1'b0, acc_exp} - {1'b0, op};
            v = (acc_exp[31] != op[31]) && (d[31] != acc_exp[31]);
            c_exp = ~d[32];
            acc_exp = (v && md[1]) ? (acc_exp[31] ? sttr_pkg::ACC_NEG_MAX :
                      sttr_pkg::ACC_POS_MAX) : d[31:0];
        end
        if (base < 0) base = cyc;
        chk("cycles", base + extra, cyc);
        chk("acc", acc_exp, acc_o);
        chk("carry", {31'h0, c_exp}, {31'h0, carry_o});
        if (v) chk("overflow", 32'h1, {31'h0, overflow_o});
    endtask : sub_step

    // table read: step flag turns on the address check, for direct and indirect forms
    task automatic tbl_step(input logic [15:0] ins, input logic [15:0] rep,
            input logic [3:0] pl, input logic ca, input int extra);
        int cyc;
        pfc0 = acc_exp[15:0];
        dst0 = ins[7] ? 16'h0 : {9'h0, ins[6:0]}; // indirect: aux 0 from reset
        chk_addr = ca;
        wr_cnt = 0;
        run_op(ins, rep, pl, 4'h0, 4'h0, 3'b000, cyc);
        @(posedge core_clk_i);
        #1;
        if (tbase < 0) tbase = cyc;
        chk("tbl cycles", tbase + extra, cyc);
        chk("word count", rep + 32'h1, wr_cnt);
        chk("pfc restored", 32'h0, {16'h0, pmem_addr_o});
        chk("acc kept", acc_exp, acc_o);
        chk("carry kept", {31'h0, c_exp}, {31'h0, carry_o});
    endtask : tbl_step

    task automatic load_temp(input logic [15:0] v);
        @(posedge core_clk_i);
        tload_i      <= 1'b1;
        tload_data_i <= v;
        @(posedge core_clk_i);
        tload_i <= 1'b0;
        @(posedge core_clk_i);
        #1;
        chk("shift temp", {16'h0, v}, {16'h0, shift_temp_o});
    endtask : load_temp

    // ******************************************************************
    // main sequence
    // ******************************************************************
    initial begin
        int cyc;
        {issue_i, tload_i, instr_i, repeat_i, tload_data_i} = '0;
        {place_i, mode_i, wait_d_i, wait_p_i} = '0;
        {miscompares, checks_done, wr_cnt} = '0;
        base = -1;
        tbase = -1;
        acc_exp = 32'h0;
        c_exp = 1'b0;
        chk_addr = 1'b0;
        {pfc0, dst0} = '0;
        reset_i = 1'b1;
        repeat (20) @(posedge core_clk_i);
        // preload after time zero so the model's own fill cannot win
        MEM.mem[8'h02] = 16'hf003;
        MEM.mem[8'h7f] = 16'h0006;
        MEM.mem[8'h10] = 16'h8000;
        reset_i <= 1'b0;
        @(posedge core_clk_i);
        #1;
        chk("idle ready", 32'h1, {31'h0, ready_o});
        chk("reset acc", 32'h0, acc_o);
        sub_step(16'h6602, 16'h0, 32'h0000_f003, 4'b0000, 4'h0, 4'h0, 3'b100, 0);
        load_temp(16'h0008);
        sub_step(16'h677f, 16'h0, 32'h0000_0600, 4'b0010, 4'h0, 4'h0, 3'b000, 1);
        load_temp(16'h00ff);
        sub_step(16'h6710, 16'h0, 32'hc000_0000, 4'b1000, 4'h3, 4'h0, 3'b100, 3);
        sub_step(16'h6710, 16'h0, 32'hc000_0000, 4'b1100, 4'h2, 4'h1, 3'b110, 4);
        sub_step(16'h6710, 16'h0, 32'hc000_0000, 4'b0000, 4'h0, 4'h0, 3'b110, 0);
        sub_step(16'h6710, 16'h0, 32'h4000_0000, 4'b0000, 4'h0, 4'h0, 3'b000, 0);
        sub_step(16'h6602, 16'h2, 32'h0000_f003, 4'b0000, 4'h0, 4'h0, 3'b100, 2);
        // opcodes outside the three are ignored and ready stays up
        run_op(16'h0000, 16'h0, 4'b0000, 4'h0, 4'h0, 3'b000, cyc);
        chk("refused cycles", 32'h0, cyc);
        chk("refused acc", acc_exp, acc_o);
        tbl_step(16'ha620, 16'h0, 4'b0000, 1'b1, 0);
        tbl_step(16'ha621, 16'h0, 4'b0010, 1'b1, 1);
        tbl_step(16'ha680, 16'h3, 4'b0000, 1'b1, 3);
        tbl_step(16'ha622, 16'h3, 4'b0001, 1'b1, 5);
        tbl_step(16'ha623, 16'h3, 4'b0011, 1'b1, 7);
        give_verdict();
    end
endmodule : subtract_table_read_exec_tb
`default_nettype wire
